// ==== isq_timer_defs.svh ====
`ifndef ISQ_TIMER_DEFS_SVH
`define ISQ_TIMER_DEFS_SVH

// register addresses on the special function register port
`define ADDR_PORT0_LATCH     16'hff00
`define ADDR_PORT0_DIR       16'hff20
`define ADDR_COUNT           16'hffb0
`define ADDR_PRIMARY         16'hffb2
`define ADDR_SECONDARY       16'hffb4
`define ADDR_MODE            16'hffb6
`define ADDR_PRESCALE        16'hffb7
`define ADDR_OUTCTL          16'hffb8

// reset values
`define RST_PORT0_DIR        8'hff
`define RST_PORT0_LATCH      8'h00
`define RST_PRESCALE         8'h00
`define RST_OUTCTL           8'h00
`define RST_MODE             2'h0
`define RST_COUNT            16'h0000
`define RST_COMPARE          16'h0000

// mode control field
`define MODE_HI_BIT          3
`define MODE_LO_BIT          2
`define MODE_STOP            2'h0
`define MODE_INTERVAL        2'h3

// output control fields
`define OUTCTL_ENABLE_BIT    0
`define OUTCTL_TOGGLE_BIT    1

// prescale select fields
`define SECOND_EDGE_HI_BIT   7
`define SECOND_EDGE_LO_BIT   6
`define FIRST_EDGE_HI_BIT    5
`define FIRST_EDGE_LO_BIT    4
`define CLOCK_SEL_HI_BIT     1
`define CLOCK_SEL_LO_BIT     0

// edge select encodings
`define EDGE_FALL            2'h0
`define EDGE_RISE            2'h1
`define EDGE_BOTH            2'h3

// clock select encodings and divider depths
`define CLK_FULL             2'h0
`define CLK_DIV16            2'h1
`define CLK_DIV64            2'h2
`define CLK_EXT              2'h3
`define DIV16_LOG2           4
`define DIV64_LOG2           6

// port 0 pin assignment
`define TIMER_OUT_PIN        6
`define FIRST_IN_PIN         5
`define SECOND_IN_PIN        6
`define PORT0_PINS           7

`endif

// ==== isq_timer_pkg.sv ====
`include "isq_timer_defs.svh"

package isq_timer_pkg;
  typedef logic [1:0]  sel_t;
  typedef logic [15:0] count_t;
  typedef logic [7:0]  byte_t;

  // valid edge decode, shared by both input filters
  function automatic logic edge_hit(input sel_t sel, input logic rise, input logic fall);
    edge_hit = ((sel == `EDGE_FALL) & fall) |
               ((sel == `EDGE_RISE) & rise) |
               ((sel == `EDGE_BOTH) & (rise | fall));
  endfunction : edge_hit
endpackage : isq_timer_pkg

// ==== count_tick_if.sv ====
`timescale 1ns/100ps

interface count_tick_if;
  logic                run;
  isq_timer_pkg::sel_t clk_sel;
  logic                ext_edge;
  logic                tick;

  modport source (input run, input clk_sel, input ext_edge, output tick);
  modport sink   (output run, output clk_sel, output ext_edge, input tick);
endinterface : count_tick_if

// ==== pin_edge_filter.sv ====
`timescale 1ns/100ps
`include "isq_timer_defs.svh"

module pin_edge_filter (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_pin,
  input  wire isq_timer_pkg::sel_t i_edge_sel,
  output logic                     o_edge
);
  import isq_timer_pkg::*;

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic level_r;
  logic level_nxt;
  logic rise;
  logic fall;

  // level accepted only after two equal samples in a row, so a one-cycle glitch never counts
  assign level_nxt = (sync_r == prev_r) ? sync_r : level_r;  // RULE_04
  assign rise      = level_nxt & ~level_r;
  assign fall      = ~level_nxt & level_r;

  // meta_r is read by sync_r alone
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_r  <= 1'b0;
      sync_r  <= 1'b0;
      prev_r  <= 1'b0;
      level_r <= 1'b0;
      o_edge  <= 1'b0;
    end else begin
      meta_r  <= i_pin;
      sync_r  <= meta_r;
      prev_r  <= sync_r;
      level_r <= level_nxt;
      o_edge  <= edge_hit(i_edge_sel, rise, fall);  // RULE_01 RULE_02
    end
  end

  // prohibited encoding yields no edge at all
  no_prohibited_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_01
    o_edge |-> $past(i_edge_sel) != 2'h2)
    else $error("edge reported under prohibited select");

  rise_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_02
    o_edge && $past(i_edge_sel) == `EDGE_RISE |-> level_r && !$past(level_r))
    else $error("rising select reported a non-rising edge");
endmodule : pin_edge_filter

// ==== count_prescaler.sv ====
`timescale 1ns/100ps
`include "isq_timer_defs.svh"

module count_prescaler #(
  parameter int DIV_LO_LOG2 = `DIV16_LOG2,
  parameter int DIV_HI_LOG2 = `DIV64_LOG2
) (
  input  wire logic     i_ref_clk,
  input  wire logic     i_rst_b,
  count_tick_if.source  tick_if
);
  import isq_timer_pkg::*;

  logic [DIV_HI_LOG2-1:0] div_r;
  logic                   lo_wrap;
  logic                   hi_wrap;

  // divider held at zero while stopped, so the first tick lands a full period after start
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !tick_if.run) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // clock select
  assign lo_wrap      = &div_r[DIV_LO_LOG2-1:0];
  assign hi_wrap      = &div_r;
  assign tick_if.tick = tick_if.run & (                         // RULE_03
                          (tick_if.clk_sel == `CLK_FULL)  |
                          ((tick_if.clk_sel == `CLK_DIV16) & lo_wrap) |
                          ((tick_if.clk_sel == `CLK_DIV64) & hi_wrap) |
                          ((tick_if.clk_sel == `CLK_EXT)   & tick_if.ext_edge));

  div16_gap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_03
    tick_if.tick && tick_if.clk_sel == `CLK_DIV16 && tick_if.run |=> !tick_if.tick [*8])
    else $error("divide-by-16 ticks too close");
endmodule : count_prescaler

// ==== interval_square_wave_timer.sv ====
// Functional notes
// RULE_01 - second input edge: fall, rise, both
// RULE_02 - first input edge: same encoding
// RULE_03 - clock select: full, /16, /64, edge
// RULE_04 - external pulses last two clocks minimum
// RULE_05 - direction bit 0 output, 1 input
// RULE_06 - direction register resets to all ones
// RULE_07 - timer output needs direction, latch zero
// RULE_08 - timer input needs direction one
// RULE_09 - mode 11 starts counting with clock
// RULE_10 - primary match clears counter, raises interrupt
// RULE_11 - match interval is M plus one
// RULE_12 - primary compare never loaded with zero
// RULE_13 - secondary match always raises its interrupt
// RULE_14 - mask secondary interrupt when unused
// RULE_15 - counter read returns current count
// RULE_16 - square wave needs output control 03H
// RULE_17 - square mode toggles output each match
// RULE_18 - output disabled holds pin low
// RULE_19 - mode 00 stops and clears counter
// RULE_20 - prescaler untouched while running
// RULE_21 - counter read has no side effect
`timescale 1ns/100ps
`include "isq_timer_defs.svh"

module interval_square_wave_timer (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_b,
  input  wire logic [15:0]               i_sfr_addr,
  input  wire logic [15:0]               i_sfr_wdata,
  input  wire logic                      i_sfr_wr,
  input  wire logic                      i_sfr_rd,
  output logic      [15:0]               o_sfr_rdata,
  input  wire logic [`PORT0_PINS-1:0]    i_port0_in,
  output logic      [`PORT0_PINS-1:0]    o_port0_out,
  output logic      [`PORT0_PINS-1:0]    o_port0_oe_b,
  output logic                           o_primary_match_irq,
  output logic                           o_secondary_match_irq,
  output logic                           o_second_input_event
);
  import isq_timer_pkg::*;

  // address decode, used for every register
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    hit = (addr == target);
  endfunction : hit

  byte_t  port0_dir_r;
  byte_t  port0_latch_r;
  byte_t  prescale_r;
  byte_t  outctl_r;
  sel_t   mode_r;
  count_t primary_r;
  count_t secondary_r;
  count_t count_r;
  count_t count_nxt;
  logic   level_r;
  logic   level_nxt;
  logic   first_edge;
  logic   run;
  logic   tick;
  logic   step;
  logic   match_p;
  logic   match_s;
  logic   p_evt;
  logic   s_evt;
  logic   wr_dir;
  logic   wr_latch;
  logic   wr_pre;
  logic   wr_out;
  logic   wr_mode;
  logic   wr_pri;
  logic   wr_sec;
  logic   timer_pin;
  logic [15:0] rd_mux;

  count_tick_if tick_if ();

  // write strobes
  assign wr_dir   = i_sfr_wr & hit(i_sfr_addr, `ADDR_PORT0_DIR);
  assign wr_latch = i_sfr_wr & hit(i_sfr_addr, `ADDR_PORT0_LATCH);
  assign wr_pre   = i_sfr_wr & hit(i_sfr_addr, `ADDR_PRESCALE);
  assign wr_out   = i_sfr_wr & hit(i_sfr_addr, `ADDR_OUTCTL);
  assign wr_mode  = i_sfr_wr & hit(i_sfr_addr, `ADDR_MODE);
  assign wr_pri   = i_sfr_wr & hit(i_sfr_addr, `ADDR_PRIMARY);
  assign wr_sec   = i_sfr_wr & hit(i_sfr_addr, `ADDR_SECONDARY);

  // configuration registers; prescale rewrite while running is left to software
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      port0_dir_r   <= `RST_PORT0_DIR;  // RULE_06
      port0_latch_r <= `RST_PORT0_LATCH;
      prescale_r    <= `RST_PRESCALE;   // RULE_20
      outctl_r      <= `RST_OUTCTL;
      mode_r        <= `RST_MODE;
      primary_r     <= `RST_COMPARE;
      secondary_r   <= `RST_COMPARE;
    end else begin
      if (wr_dir)   port0_dir_r   <= {1'b1, i_sfr_wdata[6:0]};
      if (wr_latch) port0_latch_r <= i_sfr_wdata[7:0];
      if (wr_pre)   prescale_r    <= {i_sfr_wdata[7:4], 2'h0, i_sfr_wdata[1:0]};
      if (wr_out)   outctl_r      <= {6'h00, i_sfr_wdata[1:0]};
      if (wr_mode)  mode_r        <= i_sfr_wdata[`MODE_HI_BIT:`MODE_LO_BIT];
      if (wr_pri)   primary_r     <= i_sfr_wdata;  // RULE_12
      if (wr_sec)   secondary_r   <= i_sfr_wdata;
    end
  end

  // input filters; input use relies on software setting the direction bit to one
  pin_edge_filter u_first_in (                                    // RULE_08
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_pin      (i_port0_in[`FIRST_IN_PIN]),
    .i_edge_sel (prescale_r[`FIRST_EDGE_HI_BIT:`FIRST_EDGE_LO_BIT]),
    .o_edge     (first_edge)
  );

  pin_edge_filter u_second_in (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_pin      (i_port0_in[`SECOND_IN_PIN]),
    .i_edge_sel (prescale_r[`SECOND_EDGE_HI_BIT:`SECOND_EDGE_LO_BIT]),
    .o_edge     (o_second_input_event)
  );

  // count clock source
  assign run              = (mode_r == `MODE_INTERVAL);  // RULE_09
  assign tick_if.run      = run;
  assign tick_if.clk_sel  = prescale_r[`CLOCK_SEL_HI_BIT:`CLOCK_SEL_LO_BIT];
  assign tick_if.ext_edge = first_edge;
  assign tick             = tick_if.tick;

  count_prescaler #(
    .DIV_LO_LOG2 (`DIV16_LOG2),
    .DIV_HI_LOG2 (`DIV64_LOG2)
  ) u_prescaler (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .tick_if   (tick_if)
  );

  // compare and next count; modes other than 11 hold the counter cleared
  assign step      = run & tick;
  assign match_p   = (count_r == primary_r);
  assign match_s   = (count_r == secondary_r);
  assign p_evt     = step & match_p;
  assign s_evt     = step & match_s;
  assign count_nxt = !run  ? `RST_COUNT :            // RULE_19
                     p_evt ? `RST_COUNT :            // RULE_10 RULE_11
                     step  ? count_r + 16'h0001 :
                             count_r;

  // toggle flop ignores the output enable bit; it holds its level except on a primary match with the toggle bit set
  assign level_nxt = (p_evt & outctl_r[`OUTCTL_TOGGLE_BIT]) ? ~level_r : level_r;  // RULE_17

  // counter, interrupt pulses and output level
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      count_r               <= `RST_COUNT;
      level_r               <= 1'b0;
      o_primary_match_irq   <= 1'b0;
      o_secondary_match_irq <= 1'b0;
    end else begin
      count_r               <= count_nxt;
      level_r               <= level_nxt;
      o_primary_match_irq   <= p_evt;  // RULE_10
      o_secondary_match_irq <= s_evt;  // RULE_13 RULE_14
    end
  end

  // pin drive; timer output needs direction 0 and latch 0 from software
  assign timer_pin    = outctl_r[`OUTCTL_ENABLE_BIT] & level_r;  // RULE_18 RULE_16
  assign o_port0_oe_b = port0_dir_r[`PORT0_PINS-1:0];            // RULE_05
  assign o_port0_out  = port0_latch_r[`PORT0_PINS-1:0] |          // RULE_07
                        ({{(`PORT0_PINS-1){1'b0}}, timer_pin} << `TIMER_OUT_PIN);

  // read selection; reads only sample, unmapped reads return zero
  assign rd_mux = hit(i_sfr_addr, `ADDR_COUNT)       ? count_r :   // RULE_15
                  hit(i_sfr_addr, `ADDR_PRIMARY)     ? primary_r :
                  hit(i_sfr_addr, `ADDR_SECONDARY)   ? secondary_r :
                  hit(i_sfr_addr, `ADDR_PORT0_DIR)   ? {8'h00, port0_dir_r} :
                  hit(i_sfr_addr, `ADDR_PORT0_LATCH) ? {8'h00, port0_latch_r} :
                  hit(i_sfr_addr, `ADDR_PRESCALE)    ? {8'h00, prescale_r} :
                  hit(i_sfr_addr, `ADDR_OUTCTL)      ? {8'h00, outctl_r} :
                  hit(i_sfr_addr, `ADDR_MODE)        ? {12'h000, mode_r, 2'h0} :
                                                       16'h0000;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_sfr_rdata <= 16'h0000;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_mux;  // RULE_21
    end
  end

  // helper: ticks since the previous primary match, valid once a full period was seen
  count_t gap_r;
  logic   seen_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !run || wr_pri) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else if (p_evt) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b1;
    end else if (step) begin
      gap_r  <= gap_r + 16'h0001;
    end
  end

  sequence match_step_s;
    step && match_p;
  endsequence

  sequence cleared_irq_s;
    count_r == 16'h0000 && o_primary_match_irq;
  endsequence

  match_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_10
    match_step_s |=> cleared_irq_s)
    else $error("primary match did not clear counter and raise interrupt");

  interval_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_11
    match_step_s and seen_r |-> gap_r == primary_r)
    else $error("interval between primary matches is not M plus one");

  square_toggle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_17
    match_step_s ##0 outctl_r == 8'h03 |=> timer_pin != $past(timer_pin))
    else $error("square wave output did not invert on match");

  pin_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_18
    !outctl_r[`OUTCTL_ENABLE_BIT] |-> !timer_pin)
    else $error("timer output not low while disabled");

  second_irq_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_13
    step && match_s |=> o_secondary_match_irq)
    else $error("secondary match interrupt missing");

  stop_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_19
    wr_mode && i_sfr_wdata[`MODE_HI_BIT:`MODE_LO_BIT] == `MODE_STOP
      |=> ##1 count_r == 16'h0000 && !o_primary_match_irq)
    else $error("mode 00 did not stop and clear the counter");

  dir_reset_a: assert property (@(posedge i_ref_clk) // RULE_06
    $rose(i_rst_b) |-> o_port0_oe_b == 7'h7f)
    else $error("port direction not all inputs after reset");

  count_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_15
    i_sfr_rd && hit(i_sfr_addr, `ADDR_COUNT) |=> o_sfr_rdata == $past(count_r))
    else $error("counter read did not return current count");

  read_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_21
    i_sfr_rd && !i_sfr_wr && !step && run |=> count_r == $past(count_r))
    else $error("counter read disturbed the count");

  // read data stands until the next read, so software may fetch it late
  rdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_15
    !i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");

  stop_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_19
    !run |=> !o_primary_match_irq && !o_secondary_match_irq)
    else $error("match interrupt while stopped");

  stop_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_19
    !run |=> count_r == 16'h0000)
    else $error("counter not held at zero while stopped");

  count_step_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_09
    step && !match_p |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance on a count clock");

  count_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_09
    run && !step |=> count_r == $past(count_r))
    else $error("counter moved without a count clock");

  full_rate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_03
    run && tick_if.clk_sel == `CLK_FULL |-> step)
    else $error("undivided clock missed a count");

  irq_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_10
    o_primary_match_irq |-> count_r == 16'h0000)
    else $error("primary interrupt without a cleared counter");

  irq_single_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_11
    o_primary_match_irq && primary_r != 16'h0000 |=> !o_primary_match_irq)
    else $error("primary interrupt stood longer than one cycle");

  level_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_17
    !p_evt |=> level_r == $past(level_r))
    else $error("output level changed without a primary match");

  toggle_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_17
    p_evt && !outctl_r[`OUTCTL_TOGGLE_BIT] |=> level_r == $past(level_r))
    else $error("output level toggled with toggling disabled");

  dir_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_05
    wr_dir |=> o_port0_oe_b == $past(i_sfr_wdata[6:0]))
    else $error("direction write did not reach the pin enables");

  sec_running_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_13
    o_secondary_match_irq |-> $past(run))
    else $error("secondary interrupt while stopped");
endmodule : interval_square_wave_timer

// ==== ext_pin_model.sv ====
`timescale 1ns/100ps

// far side of port 0: pulled-up pins, an external pulse source, and the timer output
module ext_pin_model (
  input  wire logic       i_ref_clk,
  input  wire logic [6:0] i_out,
  input  wire logic [6:0] i_oe_b,
  output logic      [6:0] o_pin
);
  logic [6:0] drv_r = 7'h7f;

  // a pin the device drives shows its level; a released pin sits at the pull-up or our drive
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      o_pin[k] = i_oe_b[k] ? drv_r[k] : i_out[k];
    end
  end

  // low pulse held three clocks so the two-sample filter cannot drop it
  task automatic pulse(input int pin);
    @(posedge i_ref_clk);
    #1 drv_r[pin] = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 drv_r[pin] = 1'b1;
    repeat (3) @(posedge i_ref_clk);
  endtask : pulse
endmodule : ext_pin_model

// ==== tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
  import isq_timer_pkg::*;

  logic        clk;
  logic        rst_b;
  logic [15:0] sfr_addr;
  logic [15:0] sfr_wdata;
  logic [15:0] sfr_rdata;
  logic        sfr_wr;
  logic        sfr_rd;
  logic        pirq;
  logic        sirq;
  logic        evt;
  logic [6:0]  pin;
  logic [6:0]  pout;
  logic [6:0]  poe_b;
  int          miscompares;
  int          cmp_count;
  int          cyc;

  interval_square_wave_timer interval_square_wave_timer_inst (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata),
    .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .o_sfr_rdata(sfr_rdata), .i_port0_in(pin),
    .o_port0_out(pout), .o_port0_oe_b(poe_b), .o_primary_match_irq(pirq),
    .o_secondary_match_irq(sirq), .o_second_input_event(evt)
  );

  ext_pin_model ext_pin_model_inst (.i_ref_clk(clk), .i_out(pout), .i_oe_b(poe_b), .o_pin(pin));

  // 40 MHz clock and a free cycle count for measuring intervals
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic report_and_stop();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // one-cycle strobes; an idle cycle always separates two accesses
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask : rd

  function automatic logic pick(input int w);
    return (w == 0) ? pirq : ((w == 1) ? sirq : evt);
  endfunction : pick

  // bounded wait for a pulse; running out ends the run as a failure
  task automatic wait_pulse(input int w, output int t);
    for (int k = 0; k < 1000; k++) begin
      @(posedge clk);
      #1;
      if (pick(w) === 1'b1) begin
        t = cyc;
        return;
      end
    end
    $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    miscompares++;
    report_and_stop();
  endtask : wait_pulse

  task automatic count_pulses(input int w, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      #1 if (pick(w) === 1'b1) c++;
    end
  endtask : count_pulses

  task automatic t_reset();
    logic [15:0] d;
    rd(16'hff20, d);
    chk({8'h00, d[7:0]}, 16'h00ff);
    chk({9'h000, poe_b}, 16'h007f);
    rd(16'hffb7, d);
    chk(d, 16'h0000);
    rd(16'hff10, d);
    chk(d, 16'h0000);
    wr(16'hff20, 16'h00aa);
    chk({9'h000, poe_b}, 16'h002a);
    wr(16'hff20, 16'h00ff);
  endtask : t_reset

  // free clock, compare 2, secondary 1, a counter read in mid-run
  task automatic t_interval();
    logic [15:0] d;
    int          t1;
    int          t2;
    int          t3;
    int          n;
    wr(16'hffb2, 16'h0002);
    wr(16'hffb4, 16'h0001);
    wr(16'hffb6, 16'h000c);
    wait_pulse(0, t1);
    rd(16'hffb0, d);
    chk({15'h0000, d < 16'h0003}, 16'h0001);
    wait_pulse(0, t2);
    chk(16'(t2 - t1), 16'h0006);
    wait_pulse(1, t3);
    chk(16'(t3 - t2), 16'h0002);
    wr(16'hffb6, 16'h0000);
    rd(16'hffb0, d);
    chk(d, 16'h0000);
    count_pulses(0, 30, n);
    chk(16'(n), 16'h0000);
  endtask : t_interval

  // divided count clocks, reprogrammed only while stopped
  task automatic t_prescale();
    int t1;
    int t2;
    for (int k = 1; k <= 2; k++) begin
      wr(16'hffb7, 16'(k));
      wr(16'hffb2, 16'h0001);
      wr(16'hffb4, 16'hffff);
      wr(16'hffb6, 16'h000c);
      wait_pulse(0, t1);
      wait_pulse(0, t2);
      chk(16'(t2 - t1), 16'(2 << (2 + 2 * k)));
      wr(16'hffb6, 16'h0000);
    end
  endtask : t_prescale

  task automatic t_square();
    logic lv;
    int   t1;
    int   t2;
    wr(16'hff00, 16'h0000);
    wr(16'hff20, 16'h00bf);
    wr(16'hffb7, 16'h0000);
    wr(16'hffb2, 16'h0003);
    wr(16'hffb8, 16'h0003);
    wr(16'hffb6, 16'h000c);
    wait_pulse(0, t1);
    lv = pout[6];
    wait_pulse(0, t2);
    chk(16'(t2 - t1), 16'h0004);
    chk({15'h0000, pout[6]}, {15'h0000, ~lv});
    chk({15'h0000, poe_b[6]}, 16'h0000);
    wait_pulse(0, t2);
    chk({15'h0000, pout[6]}, 16'h0001);
    wr(16'hffb8, 16'h0002);
    chk({15'h0000, pout[6]}, 16'h0000);
    wr(16'hffb6, 16'h0000);
    wr(16'hff20, 16'h00ff);
  endtask : t_square

  // external edges on the first input as count clock: fall, rise, both
  task automatic t_ext();
    logic [15:0] d;
    logic [7:0]  ps [3] = '{8'h03, 8'h13, 8'h33};
    logic [15:0] per [3] = '{16'h0001, 16'h0001, 16'h0002};
    wr(16'hffb2, 16'h00ff);
    for (int k = 0; k < 3; k++) begin
      wr(16'hffb6, 16'h0000);
      wr(16'hffb7, {8'h00, ps[k]});
      wr(16'hffb6, 16'h000c);
      ext_pin_model_inst.pulse(5);
      repeat (8) @(posedge clk);
      rd(16'hffb0, d);
      chk(d, per[k]);
    end
    wr(16'hffb6, 16'h0000);
  endtask : t_ext

  // second input edge events: fall, rise, both
  task automatic t_second();
    int          n;
    logic [7:0]  sel [4] = '{8'h00, 8'h40, 8'hc0, 8'h80};
    logic [15:0] exp [4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      wr(16'hffb7, {8'h00, sel[k]});
      fork
        ext_pin_model_inst.pulse(6);
        count_pulses(2, 20, n);
      join
      chk(16'(n), exp[k]);
    end
  endtask : t_second

  // reset for two clocks, then each scenario in turn
  initial begin
    rst_b = 1'b0;
    sfr_addr = 16'h0000;
    sfr_wdata = 16'h0000;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_interval();
    t_prescale();
    t_square();
    t_ext();
    t_second();
    report_and_stop();
  end
endmodule : tb_top
